// File: core/plfc_pkg.sv
package plfc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] PLFC_SERIES_OFF = 8'h5b;
   localparam logic [7:0] PLFC_SHUNT_OFF = 8'h5c;
   localparam logic [7:0] PLFC_PARALLEL_OFF = 8'h5d;
   // Offsets are register indices; byte address is four times the index
   localparam int PLFC_ADR_W = 10;
   localparam int PLFC_NREG = 3;
   // ----------------------------------------
   // Field layout
   // ----------------------------------------
   localparam int PLFC_SEL_LSB = 0;
   localparam int PLFC_SEL_W = 5;
   localparam int PLFC_TRIM_LSB = 5;
   localparam int PLFC_TRIM_W = 2;
   localparam int PLFC_UNIMP_BIT = 7;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [4:0] PLFC_SEL_RST = 5'h07;
   localparam logic [1:0] PLFC_TRIM_RST = 2'h1;
   localparam logic [7:0] PLFC_REG_RST = 8'h27;
   localparam logic [31:0] PLFC_UNMAPPED_DATA = 32'h0000_0000;

   typedef logic [PLFC_SEL_W-1:0] plfc_sel_t;
   typedef logic [PLFC_TRIM_W-1:0] plfc_trim_t;
endpackage

// File: core/plfc_reg_if.sv
interface plfc_reg_if;
   import plfc_pkg::*;
   logic [PLFC_NREG-1:0] wr_stb;
   logic [7:0] wr_data;
   plfc_sel_t sel [PLFC_NREG];
   plfc_trim_t trim [PLFC_NREG];
   modport ctrl (output wr_stb, output wr_data, input sel, input trim);
   modport store (input wr_stb, input wr_data, output sel, output trim);
endinterface

// File: core/plfc_cap_store.sv
module plfc_cap_store
   import plfc_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Register port
   plfc_reg_if.store rif
);
   typedef struct packed {
      plfc_sel_t [PLFC_NREG-1:0] sel;
      plfc_trim_t [PLFC_NREG-1:0] trim;
   } plfc_store_s;

   plfc_store_s st_r;
   plfc_store_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < PLFC_NREG; i++) begin
         if (rif.wr_stb[i]) begin
            // Bit 7 of the write data is dropped: no storage behind it
            st_nxt.sel[i] = rif.wr_data[PLFC_SEL_LSB +: PLFC_SEL_W];
            // Trim bits keep what software writes; software restores the default
            st_nxt.trim[i] = rif.wr_data[PLFC_TRIM_LSB +: PLFC_TRIM_W];
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < PLFC_NREG; i++) begin
            st_r.sel[i] <= PLFC_SEL_RST;
            st_r.trim[i] <= PLFC_TRIM_RST;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   genvar g;
   generate
      for (g = 0; g < PLFC_NREG; g++) begin : g_out
         assign rif.sel[g] = st_r.sel[g];
         assign rif.trim[g] = st_r.trim[g];
      end
   endgenerate
endmodule

// File: core/plfc_regs.sv
// Notes on behaviour
// - Bit 7 of each capacitor register has no storage, reads zero, ignores writes.
// - Series capacitor register: read/write 5-bit select in bits 4-0, reset 00111.
// - Shunt capacitor register: read/write 5-bit select in bits 4-0, reset 00111.
// - Parallel capacitor register: read/write 5-bit select in bits 4-0, reset 00111.
// - Select code is unsigned; zero is minimum, all ones maximum, linear between.
//
// Local design decision: register access over Wishbone.
module plfc_regs
   import plfc_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [PLFC_ADR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // Capacitor selections to the analog loop filter
   output plfc_pkg::plfc_sel_t series_cap_select_out,
   output plfc_pkg::plfc_sel_t shunt_cap_select_out,
   output plfc_pkg::plfc_sel_t parallel_cap_select_out
);
   import plfc_pkg::*;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Returns a one-hot register hit; zero for an unmapped word
   function automatic logic [PLFC_NREG-1:0] plfc_decode(input logic [PLFC_ADR_W-1:0] adr);
      logic [PLFC_NREG-1:0] hit;
      hit = '0;
      if (adr[1:0] == 2'h0) begin
         hit[0] = (adr[PLFC_ADR_W-1:2] == PLFC_SERIES_OFF);
         hit[1] = (adr[PLFC_ADR_W-1:2] == PLFC_SHUNT_OFF);
         hit[2] = (adr[PLFC_ADR_W-1:2] == PLFC_PARALLEL_OFF);
      end
      return hit;
   endfunction

   // Packs a register for reading; bit 7 has no storage and reads zero
   function automatic logic [31:0] plfc_read_word(input plfc_trim_t trim, input plfc_sel_t sel);
      return {24'h00_0000, 1'b0, trim, sel};
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      plfc_sel_t series;
      plfc_sel_t shunt;
      plfc_sel_t parallel;
   } plfc_bus_s;

   plfc_bus_s st_r;
   plfc_bus_s st_nxt;
   plfc_reg_if rif ();
   logic req;
   logic [PLFC_NREG-1:0] hit;

   // ----------------------------------------
   // Capacitor store
   // ----------------------------------------
   plfc_cap_store u_store (
      .clock_in(clock_in),
      .rst_b_in(rst_b_in),
      .rif(rif)
   );

   // ----------------------------------------
   // Bus response
   // ----------------------------------------
   // Ack in the cycle after the request and drop it for one cycle, so a held request is taken once
   assign req = wb_cyc_in && wb_stb_in && !st_r.ack;
   assign hit = plfc_decode(wb_adr_in);
   // Only byte lane 0 carries register data; other lanes are ignored
   assign rif.wr_stb = (req && wb_we_in && wb_sel_in[0]) ? hit : '0;
   assign rif.wr_data = wb_dat_in[7:0];

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = req;
      st_nxt.dat = PLFC_UNMAPPED_DATA;
      if (req && !wb_we_in) begin
         for (int i = 0; i < PLFC_NREG; i++) begin
            if (hit[i]) begin
               // Bit 7 and upper lanes read zero
               st_nxt.dat = plfc_read_word(rif.trim[i], rif.sel[i]);
            end
         end
      end
      // Codes pass straight to the filter as unsigned linear selections
      st_nxt.series = rif.sel[0];
      st_nxt.shunt = rif.sel[1];
      st_nxt.parallel = rif.sel[2];
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r.ack <= 1'b0;
         st_r.dat <= PLFC_UNMAPPED_DATA;
         st_r.series <= PLFC_SEL_RST;
         st_r.shunt <= PLFC_SEL_RST;
         st_r.parallel <= PLFC_SEL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Every output is a flop of the state struct, so the filter never sees decode glitches
   assign wb_ack_out = st_r.ack;
   assign wb_dat_out = st_r.dat;
   assign series_cap_select_out = st_r.series;
   assign shunt_cap_select_out = st_r.shunt;
   assign parallel_cap_select_out = st_r.parallel;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_b_in);

   unimp_reads_zero_a: assert property (wb_ack_out |-> wb_dat_out[31:PLFC_UNIMP_BIT] == '0)
      else $error("Unimplemented bits read nonzero");
   ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("Ack held two cycles");
   ack_follows_req_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("Ack did not follow request");
   series_write_a: assert property (rif.wr_stb[0] |-> ##2 series_cap_select_out == $past(wb_dat_in[4:0], 2))
      else $error("Series select not written");
   shunt_write_a: assert property (rif.wr_stb[1] |-> ##2 shunt_cap_select_out == $past(wb_dat_in[4:0], 2))
      else $error("Shunt select not written");
   parallel_write_a: assert property (rif.wr_stb[2] |-> ##2 parallel_cap_select_out == $past(wb_dat_in[4:0], 2))
      else $error("Parallel select not written");
   readback_a: assert property (req && !wb_we_in && hit[0] |=> wb_dat_out[4:0] == series_cap_select_out)
      else $error("Readback mismatch");
   hold_a: assert property (rif.wr_stb == '0 |=> $stable(rif.sel[1]))
      else $error("Select changed without write");
   unmapped_a: assert property (req && hit == '0 |=> wb_dat_out == '0)
      else $error("Unmapped read nonzero");

   // ----------------------------------------
   // Checks: decode and handshake
   // ----------------------------------------
   // Refused requests are still acked, so a master never hangs on a bad address
   idle_no_ack_a: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
      else $error("Ack without a request");
   idle_data_zero_a: assert property (!wb_ack_out |-> wb_dat_out == '0)
      else $error("Read data outside ack");
   write_data_zero_a: assert property (req && wb_we_in |=> wb_dat_out == '0)
      else $error("Write returned read data");
   misaligned_a: assert property (wb_adr_in[1:0] != 2'h0 |-> hit == '0)
      else $error("Misaligned address decoded");
   wr_onehot_a: assert property ($onehot0(rif.wr_stb))
      else $error("Write strobe hits two registers");
   wr_needs_req_a: assert property (rif.wr_stb != '0 |-> req && wb_we_in && wb_sel_in[0])
      else $error("Write strobe without a write request");
   read_no_write_a: assert property (req && !wb_we_in |-> rif.wr_stb == '0)
      else $error("Read changed a register");

   // ----------------------------------------
   // Checks: register storage
   // ----------------------------------------
   // Trim bits carry no hardware guard; these only check that storage follows the bus
   series_trim_a: assert property (rif.wr_stb[0]
      |=> rif.trim[0] == $past(wb_dat_in[PLFC_TRIM_LSB +: PLFC_TRIM_W]))
      else $error("Series trim bits not written");
   shunt_trim_a: assert property (rif.wr_stb[1]
      |=> rif.trim[1] == $past(wb_dat_in[PLFC_TRIM_LSB +: PLFC_TRIM_W]))
      else $error("Shunt trim bits not written");
   parallel_trim_a: assert property (rif.wr_stb[2]
      |=> rif.trim[2] == $past(wb_dat_in[PLFC_TRIM_LSB +: PLFC_TRIM_W]))
      else $error("Parallel trim bits not written");
   ignored_write_a: assert property (req && wb_we_in && (hit == '0 || !wb_sel_in[0])
      |=> $stable(rif.sel[0]) && $stable(rif.sel[1]) && $stable(rif.sel[2])
      && $stable(rif.trim[0]) && $stable(rif.trim[1]) && $stable(rif.trim[2]))
      else $error("Refused write changed a register");
   series_hold_a: assert property (rif.wr_stb == '0 |=> $stable(rif.sel[0]))
      else $error("Series select changed without write");
   parallel_hold_a: assert property (rif.wr_stb == '0 |=> $stable(rif.sel[2]))
      else $error("Parallel select changed without write");
   trim_hold_a: assert property (rif.wr_stb == '0
      |=> $stable(rif.trim[0]) && $stable(rif.trim[1]) && $stable(rif.trim[2]))
      else $error("Trim bits changed without write");

   // ----------------------------------------
   // Checks: readback and filter outputs
   // ----------------------------------------
   series_trim_readback_a: assert property (req && !wb_we_in && hit[0]
      |=> wb_dat_out[PLFC_TRIM_LSB +: PLFC_TRIM_W] == $past(rif.trim[0]))
      else $error("Series trim readback mismatch");
   shunt_readback_a: assert property (req && !wb_we_in && hit[1]
      |=> wb_dat_out[PLFC_UNIMP_BIT-1:0] == {$past(rif.trim[1]), shunt_cap_select_out})
      else $error("Shunt readback mismatch");
   parallel_readback_a: assert property (req && !wb_we_in && hit[2]
      |=> wb_dat_out[PLFC_UNIMP_BIT-1:0] == {$past(rif.trim[2]), parallel_cap_select_out})
      else $error("Parallel readback mismatch");
   series_follow_a: assert property (series_cap_select_out == $past(rif.sel[0]))
      else $error("Series output does not follow register");
   shunt_follow_a: assert property (shunt_cap_select_out == $past(rif.sel[1]))
      else $error("Shunt output does not follow register");
   parallel_follow_a: assert property (parallel_cap_select_out == $past(rif.sel[2]))
      else $error("Parallel output does not follow register");

   read_cov: cover property (req && !wb_we_in && hit[0]);
   write_cov: cover property (rif.wr_stb[2]);
   unmapped_cov: cover property (req && hit == '0);
   masked_write_cov: cover property (req && wb_we_in && !wb_sel_in[0]);
   write_read_cov: cover property (rif.wr_stb[2] ##[1:8] (req && !wb_we_in));
endmodule

// File: test/plfc_regs_tb_top.sv
module plfc_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import plfc_pkg::*;
   // ----------------------------------------
   // Signals and scoreboard
   // ----------------------------------------
   logic clock_in, rst_b_in, cyc, stb, we, ack;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] dw, dr, d;
   plfc_sel_t s0, s1, s2;
   logic [7:0] shadow [3];
   logic [31:0] exp_q [$];
   int err_total, samples_checked, seed;

   plfc_regs u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw), .wb_dat_out(dr),
      .wb_ack_out(ack), .series_cap_select_out(s0), .shunt_cap_select_out(s1),
      .parallel_cap_select_out(s2));

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Request held until ack is seen at a rising edge, then released
   task automatic bus(input logic w, input logic [9:0] a, input logic [3:0] s, input logic [31:0] v);
      @(posedge clock_in);
      {cyc, stb, we, adr, sel, dw} <= {2'b11, w, a, s, v};
      do @(posedge clock_in); while (ack !== 1'b1);
      {cyc, stb} <= 2'b00;
   endtask

   function automatic logic [9:0] ra(input int i);
      return 10'((PLFC_SERIES_OFF + 8'(i)) * 4);
   endfunction

   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 4'hf, 32'h0000_0000);
   endtask

   task automatic wr(input int i, input logic [7:0] v);
      bus(1'b1, ra(i), 4'hf, {24'h00_0000, v});
      shadow[i] = {1'b0, v[6:0]};
   endtask

   // Select outputs lag the register by one cycle
   task automatic chk_sel();
      @(posedge clock_in);
      cmp("series", {27'h0, shadow[0][4:0]}, {27'h0, s0});
      cmp("shunt", {27'h0, shadow[1][4:0]}, {27'h0, s1});
      cmp("parallel", {27'h0, shadow[2][4:0]}, {27'h0, s2});
   endtask

   task automatic summarize();
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ----------------------------------------
   // Read data monitor
   // ----------------------------------------
   always @(posedge clock_in) begin
      if (ack === 1'b1 && we === 1'b0)
         cmp("rdata", exp_q.pop_front(), dr);
   end
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial begin
      {cyc, stb, we, adr, sel, dw} = '0;
      rst_b_in = 1'b0;
      seed = 41065;
      foreach (shadow[i]) shadow[i] = PLFC_REG_RST;
      repeat (4) @(posedge clock_in);
      rst_b_in <= 1'b1;
      chk_sel();
      for (int i = 0; i < 3; i++) rd(ra(i), 32'h0000_0027);
      // Trim bits always written back at their default
      repeat (6) begin
         for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            wr(i, {d[7], PLFC_TRIM_RST, d[4:0]});
         end
         chk_sel();
         for (int i = 0; i < 3; i++) rd(ra(i), {24'h0, shadow[i]});
      end
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 3; i++) wr(i, {1'b1, PLFC_TRIM_RST, k == 0 ? 5'h1f : 5'h00});
         chk_sel();
         for (int i = 0; i < 3; i++) rd(ra(i), {24'h0, shadow[i]});
      end
      bus(1'b1, 10'h000, 4'hf, 32'h0000_00ff);
      rd(10'h000, 32'h0000_0000);
      bus(1'b1, ra(0) + 10'h001, 4'hf, 32'h0000_0033);
      bus(1'b1, ra(0), 4'h0, 32'h0000_0035);
      rd(ra(0), {24'h0, shadow[0]});
      chk_sel();
      repeat (3) @(posedge clock_in);
      cmp("pending", 32'h0, exp_q.size());
      summarize();
   end

   initial begin
      #50us;
      err_total++;
      summarize();
   end
endmodule
